/* core/sync_port_pkg.sv */
// constants shared by the serial control and sync block
package sync_port_pkg;
    localparam int CORE_DIV = 4;
    localparam int PHASE_W = 2;
    localparam int ADDR_W = 5;
    localparam int REG_W = 32;
    localparam int NUM_REGS = 32;
    localparam logic [4:0] CFR_ONE_ADDR = 5'h00;
    localparam logic [4:0] CFR_TWO_ADDR = 5'h01;
    localparam int INSTR_RW_BIT = 7;
    localparam int PIN_CFG_BIT = 9;
    localparam int LSB_FIRST_BIT = 8;
    localparam int AUTO_ALIGN_BIT = 23;
    localparam int SW_ALIGN_BIT = 22;
    localparam int HS_ENH_BIT = 11;
    localparam int HW_ALIGN_BIT = 10;
    localparam int OSC_EN_BIT = 9;
    localparam logic [PHASE_W-1:0] RISE_PHASE = 2'h0;
    localparam logic [PHASE_W-1:0] ALIGN_PHASE = 2'h0;
    localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        ST_INSTR = 2'b01,
        ST_DATA = 2'b10
    } port_state_t;

    // bytes in each register, selected by serial address
    function automatic logic [2:0] regBytes(input logic [ADDR_W-1:0] addr);
        case (addr)
            5'h00: regBytes = 3'h4;
            5'h01: regBytes = 3'h3;
            5'h02: regBytes = 3'h2;
            5'h03: regBytes = 3'h1;
            5'h05: regBytes = 3'h2;
            default: regBytes = 3'h4;
        endcase
    endfunction : regBytes
endpackage : sync_port_pkg

/* core/serial_control_and_sync.sv */
// serial control port, update strobe and reference clock alignment
//
// Notes on behaviour
// - update strobe sampled on reference clock rising edges
// - reference clock is core clock divided by four
// - strobe edge copies buffers into active registers
// - auto align bit tracks alignment input phase
// - software align bit advances one cycle, self-clears
// - hardware align bit: input edges advance clock
// - oscillator output static until enable bit set
// - accesses cover whole registers, internal byte addresses
// - first eight serial edges form instruction byte
// - data phase byte count equals register width
// - after final byte, next eight edges instruction
// - capture on serial rise, drive on fall
// - instruction bit seven read, low five address
// - select high tristates pins and pauses cycle
// - register zero bit nine selects output pin
// - single pin mode keeps separate output quiet
// - abort input resets port, keeps register contents
// - register zero bit eight selects bit order
// - msb first descends bytes, lsb first ascends
`timescale 1ns/1ps
`default_nettype none
module serial_control_and_sync
    import sync_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serialClock,
    input wire logic selectN,
    input wire logic portAbort,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    output logic serialDataOutput,
    output logic serialDataOutputOe,
    input wire logic registerUpdate,
    input wire logic syncIn,
    input wire logic referenceClockInput,
    output logic syncClkOut,
    output logic oscOut,
    output logic hsSyncEnhance
);
    logic [REG_W-1:0] bufferReg [NUM_REGS];
    logic [REG_W-1:0] activeReg [NUM_REGS];
    logic [PHASE_W-1:0] phase_ff;
    logic [PHASE_W-1:0] nxt_phase;
    logic syncClk_ff;
    logic updSample_ff;
    logic updPulse_ff;
    logic syncInPrev_ff;
    logic osc_ff;
    logic hsEnh_ff;
    logic sclkPrev_ff;
    port_state_t state_ff;
    logic [2:0] bitCnt_ff;
    logic [1:0] byteIdx_ff;
    logic [7:0] shift_ff;
    logic [7:0] txByte_ff;
    logic readOp_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic dataBit_ff;
    logic sdioOe_ff;
    logic sdoOe_ff;
    logic sdo_ff;
    logic sclkRise;
    logic sclkFall;
    logic lsbFirst;
    logic sepOutput;
    logic syncInRise;
    logic advance;
    logic [7:0] nxt_shift;
    logic byteDone;
    logic lastByte;
    logic [2:0] bytesOfInstr;
    logic [1:0] firstIdx;
    logic [1:0] nxt_idx;
    logic [2:0] txSel;

    assign lsbFirst = activeReg[CFR_ONE_ADDR][LSB_FIRST_BIT];
    assign sepOutput = activeReg[CFR_ONE_ADDR][PIN_CFG_BIT];

    // ---------------- reference clock divider and alignment ----------------
    assign syncInRise = syncIn && !syncInPrev_ff;

    always_comb begin
        advance = activeReg[CFR_ONE_ADDR][SW_ALIGN_BIT];
        if (activeReg[CFR_ONE_ADDR][AUTO_ALIGN_BIT] && syncInRise && phase_ff != ALIGN_PHASE) begin
            advance = 1'b1;
        end
        if (activeReg[CFR_TWO_ADDR][HW_ALIGN_BIT] && syncInRise) begin
            advance = 1'b1;
        end
        // an advance skips one core cycle of the divide-by-four count
        nxt_phase = phase_ff + (advance ? 2'h2 : 2'h1);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_ff <= RISE_PHASE;
            syncClk_ff <= 1'b1;
            syncInPrev_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            syncClk_ff <= ~nxt_phase[1];
            syncInPrev_ff <= syncIn;
        end
    end

    // ---------------- update strobe ----------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            updSample_ff <= 1'b0;
            updPulse_ff <= 1'b0;
        end else if (phase_ff == RISE_PHASE) begin
            updSample_ff <= registerUpdate;
            updPulse_ff <= registerUpdate && !updSample_ff;
        end else begin
            updPulse_ff <= 1'b0;
        end
    end

    // ---------------- active control registers ----------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                activeReg[i] <= REG_RESET;
            end
        end else if (updPulse_ff) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                activeReg[i] <= bufferReg[i];
            end
        end else begin
            activeReg[CFR_ONE_ADDR][SW_ALIGN_BIT] <= 1'b0;
        end
    end

    // ---------------- oscillator output and enhancement bit ----------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            osc_ff <= 1'b0;
            hsEnh_ff <= 1'b0;
        end else begin
            osc_ff <= activeReg[CFR_TWO_ADDR][OSC_EN_BIT] && referenceClockInput;
            hsEnh_ff <= activeReg[CFR_TWO_ADDR][HS_ENH_BIT];
        end
    end

    // ---------------- serial port ----------------
    assign sclkRise = serialClock && !sclkPrev_ff && !selectN;
    assign sclkFall = !serialClock && sclkPrev_ff && !selectN;

    always_comb begin
        if (lsbFirst) begin
            nxt_shift = {sdioIn, shift_ff[7:1]};
        end else begin
            nxt_shift = {shift_ff[6:0], sdioIn};
        end
        byteDone = sclkRise && bitCnt_ff == LAST_BIT;
        bytesOfInstr = regBytes(nxt_shift[ADDR_W-1:0]);
        firstIdx = lsbFirst ? 2'h0 : 2'(bytesOfInstr - 3'h1);
        lastByte = lsbFirst ? (byteIdx_ff == 2'(regBytes(addr_ff) - 3'h1)) : (byteIdx_ff == 2'h0);
        nxt_idx = lsbFirst ? byteIdx_ff + 2'h1 : byteIdx_ff - 2'h1;
        txSel = lsbFirst ? bitCnt_ff : LAST_BIT - bitCnt_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclkPrev_ff <= 1'b0;
            state_ff <= ST_INSTR;
            bitCnt_ff <= 3'h0;
            byteIdx_ff <= 2'h0;
            shift_ff <= 8'h00;
            txByte_ff <= 8'h00;
            readOp_ff <= 1'b0;
            addr_ff <= 5'h00;
        end else begin
            sclkPrev_ff <= serialClock;
            if (portAbort) begin
                state_ff <= ST_INSTR;
                bitCnt_ff <= 3'h0;
                byteIdx_ff <= 2'h0;
            end else if (sclkRise) begin
                shift_ff <= nxt_shift;
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (byteDone) begin
                    case (state_ff)
                        ST_INSTR: begin
                            readOp_ff <= nxt_shift[INSTR_RW_BIT];
                            addr_ff <= nxt_shift[ADDR_W-1:0];
                            byteIdx_ff <= firstIdx;
                            txByte_ff <= activeReg[nxt_shift[ADDR_W-1:0]][{firstIdx, 3'h0} +: 8];
                            state_ff <= ST_DATA;
                        end
                        ST_DATA: begin
                            byteIdx_ff <= nxt_idx;
                            txByte_ff <= activeReg[addr_ff][{nxt_idx, 3'h0} +: 8];
                            if (lastByte) begin
                                state_ff <= ST_INSTR;
                            end
                        end
                        default: state_ff <= ST_INSTR;
                    endcase
                end
            end
        end
    end

    // write data lands in the buffer only on a complete byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                bufferReg[i] <= REG_RESET;
            end
        end else if (!portAbort && byteDone && state_ff == ST_DATA && !readOp_ff) begin
            bufferReg[addr_ff][{byteIdx_ff, 3'h0} +: 8] <= nxt_shift;
        end
    end

    // read data on falling edges and pin enables
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataBit_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdioOe_ff <= 1'b0;
            sdoOe_ff <= 1'b0;
        end else begin
            if (sclkFall && state_ff == ST_DATA && readOp_ff) begin
                dataBit_ff <= txByte_ff[txSel];
                sdo_ff <= txByte_ff[txSel];
            end
            sdioOe_ff <= !selectN && !portAbort && state_ff == ST_DATA && readOp_ff && !sepOutput;
            sdoOe_ff <= !selectN && !portAbort && state_ff == ST_DATA && readOp_ff && sepOutput;
        end
    end

    assign sdioOut = dataBit_ff;
    assign sdioOe = sdioOe_ff;
    assign serialDataOutput = sdo_ff;
    assign serialDataOutputOe = sdoOe_ff;
    assign syncClkOut = syncClk_ff;
    assign oscOut = osc_ff;
    assign hsSyncEnhance = hsEnh_ff;

    // ---------------- checks ----------------
    divide_count_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !advance |=> phase_ff == $past(phase_ff) + 2'h1)
    else $error("reference divider skipped without an advance");

    strobe_sample_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        updPulse_ff |-> $past(phase_ff) == RISE_PHASE && $past(registerUpdate))
    else $error("update pulse outside a reference rising edge");

    update_copy_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        updPulse_ff |=> activeReg[CFR_TWO_ADDR] == $past(bufferReg[CFR_TWO_ADDR]))
    else $error("update pulse did not copy the buffer");

    sw_selfclear_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        activeReg[CFR_ONE_ADDR][SW_ALIGN_BIT] && !updPulse_ff |=> !activeReg[CFR_ONE_ADDR][SW_ALIGN_BIT])
    else $error("software align bit did not clear");

    hw_advance_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        activeReg[CFR_TWO_ADDR][HW_ALIGN_BIT] && syncInRise |=> phase_ff == $past(phase_ff) + 2'h2)
    else $error("alignment edge did not advance the reference clock");

    select_hiz_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        selectN |=> !sdioOe && !serialDataOutputOe)
    else $error("data pin driven while deselected");

    single_pin_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !$past(sepOutput) |-> !serialDataOutputOe)
    else $error("separate output driven in single pin mode");

    abort_reset_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        portAbort |=> state_ff == ST_INSTR && bitCnt_ff == 3'h0)
    else $error("abort did not reset the port");

    osc_static_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !activeReg[CFR_TWO_ADDR][OSC_EN_BIT] |=> !oscOut)
    else $error("oscillator output moved while disabled");

    last_byte_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !portAbort && byteDone && state_ff == ST_DATA && lastByte |=> state_ff == ST_INSTR)
    else $error("port did not return to instruction phase");

    auto_align_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        activeReg[CFR_ONE_ADDR][AUTO_ALIGN_BIT] && syncInRise && phase_ff != ALIGN_PHASE |=> phase_ff == $past(phase_ff) + 2'h2)
    else $error("misaligned reference clock was not advanced");

    sw_advance_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        activeReg[CFR_ONE_ADDR][SW_ALIGN_BIT] |=> phase_ff == $past(phase_ff) + 2'h2)
    else $error("software align bit did not advance the reference clock");

    instr_count_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !portAbort && byteDone && state_ff == ST_INSTR |=> state_ff == ST_DATA)
    else $error("instruction byte did not open the data phase");

    byte_count_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !portAbort && byteDone && state_ff == ST_DATA && !lastByte |=> state_ff == ST_DATA)
    else $error("data phase ended before the register width");

    first_byte_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        !portAbort && byteDone && state_ff == ST_INSTR
        |=> byteIdx_ff == ($past(lsbFirst) ? 2'h0 : 2'(regBytes(addr_ff) - 3'h1)))
    else $error("data phase started at the wrong byte");

    read_drive_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        sclkFall && state_ff == ST_DATA && readOp_ff |=> sdioOut == $past(txByte_ff[txSel]) && serialDataOutput == sdioOut)
    else $error("read bit not driven after a serial clock fall");

    sdio_pin_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        sepOutput |=> !sdioOe)
    else $error("bidirectional pin driven in separate output mode");

    buffer_hold_a:
    assert property (@(posedge ref_clk) disable iff (reset)
        portAbort |=> bufferReg[addr_ff] == $past(bufferReg[addr_ff]))
    else $error("abort changed register contents");

    counter_start_a:
    assert property (@(posedge ref_clk)
        reset |=> bitCnt_ff == 3'h0 && state_ff == ST_INSTR)
    else $error("serial bit counter not cleared by reset");
endmodule : serial_control_and_sync
`default_nettype wire

/* bench/spi_host_model.sv */
// system controller model driving the serial control port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic ref_clk,
    output logic serialClock,
    output logic selectN,
    output logic sdioIn,
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic serialDataOutput,
    input wire logic serialDataOutputOe
);
    logic lsbFirst = 1'b0;
    logic sepPin = 1'b0;
    logic driving = 1'b1;
    logic lastBit = 1'b0;
    logic oeInPause = 1'b0;
    int pauseAt = -1;
    // released line shows the device's bit or the inverse of our last one
    assign sdioIn = driving ? lastBit : (sdioOe ? sdioOut : ~lastBit);
    initial begin
        serialClock = 1'b0;
        selectN = 1'b1;
    end

    // each level lasts two core cycles, 2.5 MHz serial clock
    task automatic half(input logic lvl);
        serialClock = lvl;
        repeat (2) @(posedge ref_clk);
        #10;
    endtask : half

    task automatic shift(input logic [31:0] v, input int nb, output logic [31:0] rd);
        int idx;
        rd = 32'h0;
        for (int k = 0; k < nb; k++) begin
            idx = lsbFirst ? k : nb - 1 - k;
            if (k == pauseAt) begin
                selectN = 1'b1;
                half(1'b0);
                half(1'b1);
                oeInPause = sdioOe | serialDataOutputOe;
                selectN = 1'b0;
            end
            lastBit = v[idx];
            half(1'b0);
            rd[idx] = sepPin ? serialDataOutput : sdioIn;
            half(1'b1);
        end
    endtask : shift

    // instruction then data bits, bit count given by caller
    task automatic xfer(input logic [7:0] instr, input int nBits, input logic [31:0] wr,
                        output logic [31:0] rd);
        logic [31:0] dummy;
        driving = 1'b1;
        selectN = 1'b0;
        shift({24'h0, instr}, 8, dummy);
        driving = ~instr[7];
        shift(wr, nBits, rd);
        half(1'b0);
        selectN = 1'b1;
        driving = 1'b1;
        half(1'b0);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* bench/serial_control_and_sync_tb.sv */
// testbench for the serial control and sync block
`timescale 1ns/1ps
`default_nettype none
module serial_control_and_sync_tb;
    logic ref_clk, reset, serialClock, selectN, portAbort, sdioIn, sdioOut, sdioOe;
    logic serialDataOutput, serialDataOutputOe, registerUpdate, syncIn, refIn = 1'b0;
    logic syncClkOut, oscOut, hsSyncEnhance, sepSeen = 1'b0, sdioSeen = 1'b0;
    logic [31:0] rd;
    int nFail = 0;
    int samplesChecked = 0;
    time t1, t2;

    serial_control_and_sync u_serial_control_and_sync (.ref_clk(ref_clk), .reset(reset),
        .serialClock(serialClock), .selectN(selectN), .portAbort(portAbort), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOutput(serialDataOutput),
        .serialDataOutputOe(serialDataOutputOe), .registerUpdate(registerUpdate), .syncIn(syncIn),
        .referenceClockInput(refIn), .syncClkOut(syncClkOut), .oscOut(oscOut),
        .hsSyncEnhance(hsSyncEnhance));
    spi_host_model u_spi_host_model (.ref_clk(ref_clk), .serialClock(serialClock),
        .selectN(selectN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .serialDataOutput(serialDataOutput), .serialDataOutputOe(serialDataOutputOe));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        refIn <= ~refIn;
        sepSeen <= sepSeen | serialDataOutputOe;
        sdioSeen <= sdioSeen | sdioOe;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkBit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkBit
    task automatic wr(input logic [4:0] a, input int nb, input logic [31:0] v);
        u_spi_host_model.xfer({3'h0, a}, 8 * nb, v, rd);
    endtask : wr
    // ignored instruction bits 6 and 5 are set on every read
    task automatic rdChk(input logic [4:0] a, input int nb, input logic [31:0] exp);
        u_spi_host_model.xfer({3'h7, a}, 8 * nb, 32'h0, rd);
        chk(rd, exp);
    endtask : rdChk
    // strobe held two reference periods high, then two low
    task automatic upd;
        registerUpdate = 1'b1;
        repeat (8) @(posedge ref_clk);
        #10 registerUpdate = 1'b0;
        repeat (8) @(posedge ref_clk);
        #10;
    endtask : upd
    task automatic rise(output time t);
        @(posedge syncClkOut);
        t = $time;
        @(posedge ref_clk);
        #10;
    endtask : rise
    task automatic stopTest;
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stopTest

    initial begin
        #3000000;
        nFail++;
        stopTest();
    end

    initial begin
        reset = 1'b1;
        portAbort = 1'b0;
        registerUpdate = 1'b0;
        syncIn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #10 reset = 1'b0;
        rise(t1);
        chkBit(syncClkOut, 1'b1);
        @(posedge ref_clk);
        #10 chkBit(syncClkOut, 1'b0);
        rise(t2);
        chk(32'(t2 - t1), 32'd400);
        chkBit(oscOut, 1'b0);
        wr(5'h01, 3, 32'h000a00);
        rdChk(5'h01, 3, 32'h0);
        chkBit(oscOut, 1'b0);
        upd();
        rdChk(5'h01, 3, 32'h000a00);
        chkBit(hsSyncEnhance, 1'b1);
        chkBit(oscOut, ~refIn);
        u_spi_host_model.pauseAt = 12;
        rdChk(5'h01, 3, 32'h000a00);
        chkBit(u_spi_host_model.oeInPause, 1'b0);
        u_spi_host_model.pauseAt = -1;
        chkBit(sepSeen, 1'b0);
        chkBit(sdioSeen, 1'b1);
        wr(5'h02, 2, 32'h1234);
        upd();
        u_spi_host_model.xfer(8'h02, 4, 32'hf, rd);
        portAbort = 1'b1;
        repeat (2) @(posedge ref_clk);
        #10 portAbort = 1'b0;
        upd();
        rdChk(5'h02, 2, 32'h1234);
        wr(5'h00, 4, 32'h300);
        upd();
        u_spi_host_model.lsbFirst = 1'b1;
        u_spi_host_model.sepPin = 1'b1;
        sepSeen = 1'b0;
        sdioSeen = 1'b0;
        rdChk(5'h00, 4, 32'h300);
        chkBit(sdioSeen, 1'b0);
        chkBit(sepSeen, 1'b1);
        wr(5'h00, 4, 32'h0040_0300);
        rise(t1);
        upd();
        rise(t2);
        chk(32'(((t2 - t1) / 100) % 4), 32'h3);
        rdChk(5'h00, 4, 32'h300);
        wr(5'h00, 4, 32'h300);
        wr(5'h01, 3, 32'h000400);
        upd();
        rise(t1);
        repeat (2) begin
            syncIn = 1'b1;
            repeat (4) @(posedge ref_clk);
            #10 syncIn = 1'b0;
            repeat (4) @(posedge ref_clk);
            #10;
        end
        rise(t2);
        chk(32'(((t2 - t1) / 100) % 4), 32'h2);
        rdChk(5'h01, 3, 32'h000400);
        // alignment input as a free running reference of another device
        wr(5'h01, 3, 32'h0);
        wr(5'h00, 4, 32'h0080_0300);
        upd();
        repeat (6) begin
            syncIn = 1'b1;
            repeat (2) @(posedge ref_clk);
            #10 syncIn = 1'b0;
            repeat (2) @(posedge ref_clk);
            #10;
        end
        chkBit(syncClkOut, 1'b1);
        @(posedge ref_clk);
        #10 chkBit(syncClkOut, 1'b1);
        @(posedge ref_clk);
        #10 chkBit(syncClkOut, 1'b0);
        stopTest();
    end
endmodule : serial_control_and_sync_tb
`default_nettype wire
